// ==== core/gdc_pkg.sv ====
// Package with register map, field layout and divider tables for the gate-drive config block
package gdc_pkg;
  localparam int unsigned ADDR_W = 4;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] BOOST_CLOCK_CONTROL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] BOOST_CURRENT_LIMIT_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] PHASE_VOLTAGE_SELECT_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] SENSE_AMP_OFFSET_TRIM_OFS = 4'hC;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 4'h0;
  // Field positions
  localparam int unsigned DIV_LSB = 2;
  localparam int unsigned DIV_MSB = 6;
  localparam int unsigned DUTY_LSB = 0;
  localparam int unsigned DUTY_MSB = 1;
  localparam int unsigned AMP1_LSB = 4;
  localparam int unsigned AMP1_MSB = 6;
  localparam int unsigned AMP0_LSB = 0;
  localparam int unsigned AMP0_MSB = 2;
  localparam int unsigned PHSEL_MSB = 1;
  // Reset values (not documented)
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] PHSEL_RESET = 2'h0;
  // Duty codes
  localparam logic [1:0] DUTY_75 = 2'h3;
  // Phase select codes
  localparam logic [1:0] PH_SUPPLY = 2'h0;
  localparam logic [1:0] PH_ZERO = 2'h1;
  localparam logic [1:0] PH_ONE = 2'h2;
  // Divider minimum and threshold for lower codes, table for upper half of divider codes
  localparam int unsigned DIV_LOW_MIN = 4;
  localparam int unsigned DIV_LOW_THRESH = 6;
  localparam logic [9:0] DIV_HIGH_TABLE [16] = '{
    10'h010, 10'h018, 10'h020, 10'h030, 10'h040, 10'h060, 10'h064, 10'h080,
    10'h0C0, 10'h0C8, 10'h100, 10'h180, 10'h190, 10'h200, 10'h300, 10'h320};
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PH_SRC_SUPPLY, PH_SRC_ZERO, PH_SRC_ONE, PH_SRC_NONE} gdc_phsrc_e;
endpackage

// ==== core/gdc_boost_clkgen.sv ====
// Boost converter clock generator: programmable divider with duty select
`timescale 1ns/1ps
module gdc_boost_clkgen #(
  parameter int unsigned CNT_W = 10
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic [4:0] div_sel_i,
  input wire logic [1:0] duty_sel_i,
  output logic boost_clk_o
);
  logic [CNT_W-1:0] ratio;
  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] cnt_q;
  logic clk_q;

  always_comb begin
    if (div_sel_i[4]) begin
      ratio = CNT_W'(gdc_pkg::DIV_HIGH_TABLE[div_sel_i[3:0]]);
    end else if (div_sel_i[3:1] < 3'(gdc_pkg::DIV_LOW_THRESH / 2)) begin
      ratio = CNT_W'(gdc_pkg::DIV_LOW_MIN);
    end else begin
      ratio = CNT_W'(div_sel_i[3:0] & 4'hE);
    end
    if (div_sel_i[4] && duty_sel_i == gdc_pkg::DUTY_75) begin
      high_cnt = CNT_W'((ratio * 3) >> 2);
    end else begin
      high_cnt = ratio >> 1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else if (ce_i) begin
      if (!enable_i) begin
        // Parked at the wrap point so the first high phase is full
        cnt_q <= ratio - 1'b1;
        clk_q <= 1'b0;
      end else begin
        cnt_q <= (cnt_q >= ratio - 1'b1) ? '0 : cnt_q + 1'b1;
        clk_q <= ((cnt_q >= ratio - 1'b1) ? '0 : cnt_q + 1'b1) < high_cnt;
      end
    end
  end

  assign boost_clk_o = clk_q;
endmodule

// ==== core/gdc_top.sv ====
// Gate-drive boost clock, current limit, phase mux and sense offset registers
`timescale 1ns/1ps
// Overview of operation
// - Boost clock and current limit registers always readable, writable only when unlocked
// - Five-bit divider select at bits 6..2 sets boost clock ratio
// - Codes up to 00101 divide by 4, then twice upper four bits
// - Codes 10000..11111 divide by 16 through 800 per table
// - Duty select at bits 1..0; divider msb zero forces 50% duty
// - With divider msb set, duty 00/10 give 50%, 11 gives 75%
// - Current limit setting held and driven to analog boost circuitry
// - Phase select written to buffer, moved to active on reload-ok and reload
// - Reading phase select returns buffered value, not active one
// - Active select routes supply/12, phase zero/6 or phase one/6 to ADC
// - Phase select and offset trim registers writable regardless of lock
// - Two three-bit offset trims: bits 6..4 amp one, 2..0 amp zero
// - Offset codes map to zero, positive and negative millivolt steps
module gdc_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic config_write_lock_i,
  input wire logic boost_enable_bit_i,
  input wire logic pwm_reload_ok_i,
  input wire logic pwm_reload_i,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic boost_clk_o,
  output logic [7:0] boost_current_limit_o,
  output logic [1:0] phase_volt_select_o,
  output logic sel_bridge_supply_pin_o,
  output logic sel_phase_zero_pin_o,
  output logic sel_phase_one_pin_o,
  output logic [2:0] amp_one_offset_trim_o,
  output logic [2:0] amp_zero_offset_trim_o,
  output logic signed [4:0] amp_one_offset_step_o,
  output logic signed [4:0] amp_zero_offset_step_o
);
  logic lock_s1_q;
  logic lock_q;
  logic [7:0] clk_ctrl_q;
  logic [7:0] bcl_q;
  logic [1:0] ph_buf_q;
  logic [1:0] ph_act_q;
  logic [7:0] cso_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic [3:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_en;
  logic wr_hit;
  logic [7:0] rd_byte;
  logic rd_hit;
  gdc_pkg::gdc_phsrc_e ph_src;
  logic sel_sup_q;
  logic sel_zero_q;
  logic sel_one_q;
  logic signed [4:0] step_one_q;
  logic signed [4:0] step_zero_q;

  // Lock level arrives from another block's pin
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_s1_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (ce_i) begin
      lock_s1_q <= config_write_lock_i;
      lock_q <= lock_s1_q;
    end
  end

  // Write channel capture, either order
  assign s_axi_awready = ce_i && !aw_hold_q && !bvalid_q;
  assign s_axi_wready = ce_i && !w_hold_q && !bvalid_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      w_hold_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_addr = {awaddr_q[3:2], 2'b00};
  assign wr_byte = wdata_q[7:0];
  assign wr_en = wr_fire && wstrb0_q;

  always_comb begin
    case (wr_addr)
      gdc_pkg::BOOST_CLOCK_CONTROL_OFS,
      gdc_pkg::BOOST_CURRENT_LIMIT_OFS,
      gdc_pkg::PHASE_VOLTAGE_SELECT_OFS,
      gdc_pkg::SENSE_AMP_OFFSET_TRIM_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Response code kept until the next write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bresp_q <= gdc_pkg::RESP_OKAY;
    end else if (ce_i && wr_fire) begin
      bresp_q <= wr_hit ? gdc_pkg::RESP_OKAY : gdc_pkg::RESP_SLVERR;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // locked clock control, field layout kept
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clk_ctrl_q <= gdc_pkg::REG_RESET;
    end else if (ce_i && wr_en && !lock_q) begin
      if (wr_addr == gdc_pkg::BOOST_CLOCK_CONTROL_OFS) begin
        clk_ctrl_q <= {1'b0, wr_byte[gdc_pkg::DIV_MSB:gdc_pkg::DUTY_LSB]};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bcl_q <= gdc_pkg::REG_RESET;
    end else if (ce_i && wr_en && !lock_q) begin
      if (wr_addr == gdc_pkg::BOOST_CURRENT_LIMIT_OFS) begin
        bcl_q <= wr_byte;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ph_buf_q <= gdc_pkg::PHSEL_RESET;
    end else if (ce_i && wr_en) begin
      if (wr_addr == gdc_pkg::PHASE_VOLTAGE_SELECT_OFS) begin
        ph_buf_q <= wr_byte[gdc_pkg::PHSEL_MSB:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cso_q <= gdc_pkg::REG_RESET;
    end else if (ce_i && wr_en) begin
      if (wr_addr == gdc_pkg::SENSE_AMP_OFFSET_TRIM_OFS) begin
        cso_q <= {1'b0, wr_byte[gdc_pkg::AMP1_MSB:gdc_pkg::AMP1_LSB], 1'b0,
                  wr_byte[gdc_pkg::AMP0_MSB:gdc_pkg::AMP0_LSB]};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ph_act_q <= gdc_pkg::PHSEL_RESET;
    end else if (ce_i && pwm_reload_ok_i && pwm_reload_i) begin
      ph_act_q <= ph_buf_q;
    end
  end

  // Read path; buffered readback
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[3:2], 2'b00})
      gdc_pkg::BOOST_CLOCK_CONTROL_OFS: rd_byte = clk_ctrl_q;
      gdc_pkg::BOOST_CURRENT_LIMIT_OFS: rd_byte = bcl_q;
      gdc_pkg::PHASE_VOLTAGE_SELECT_OFS: rd_byte = {6'h00, ph_buf_q};
      gdc_pkg::SENSE_AMP_OFFSET_TRIM_OFS: rd_byte = cso_q;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ce_i && !rvalid_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Read data captured as the address is taken
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
      rresp_q <= gdc_pkg::RESP_OKAY;
    end else if (ce_i && s_axi_arvalid && !rvalid_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? gdc_pkg::RESP_OKAY : gdc_pkg::RESP_SLVERR;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // routing of the select about to become active
  always_comb begin
    case (ph_buf_q)
      gdc_pkg::PH_SUPPLY: ph_src = gdc_pkg::PH_SRC_SUPPLY;
      gdc_pkg::PH_ZERO: ph_src = gdc_pkg::PH_SRC_ZERO;
      gdc_pkg::PH_ONE: ph_src = gdc_pkg::PH_SRC_ONE;
      default: ph_src = gdc_pkg::PH_SRC_NONE;
    endcase
  end

  // pin selects registered together with the active select
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sel_sup_q <= gdc_pkg::PHSEL_RESET == gdc_pkg::PH_SUPPLY;
      sel_zero_q <= gdc_pkg::PHSEL_RESET == gdc_pkg::PH_ZERO;
      sel_one_q <= gdc_pkg::PHSEL_RESET == gdc_pkg::PH_ONE;
    end else if (ce_i && pwm_reload_ok_i && pwm_reload_i) begin
      sel_sup_q <= ph_src == gdc_pkg::PH_SRC_SUPPLY;
      sel_zero_q <= ph_src == gdc_pkg::PH_SRC_ZERO;
      sel_one_q <= ph_src == gdc_pkg::PH_SRC_ONE;
    end
  end

  assign phase_volt_select_o = ph_act_q;
  assign sel_bridge_supply_pin_o = sel_sup_q;
  assign sel_phase_zero_pin_o = sel_zero_q;
  assign sel_phase_one_pin_o = sel_one_q;

  assign boost_current_limit_o = bcl_q;
  assign amp_one_offset_trim_o = cso_q[gdc_pkg::AMP1_MSB:gdc_pkg::AMP1_LSB];
  assign amp_zero_offset_trim_o = cso_q[gdc_pkg::AMP0_MSB:gdc_pkg::AMP0_LSB];

  function automatic logic signed [4:0] offset_step(input logic [2:0] code);
    logic signed [4:0] s;
    s = 5'sd0;
    case (code)
      3'h1: s = 5'sd1;
      3'h2: s = 5'sd2;
      3'h3: s = 5'sd3;
      3'h5: s = -5'sd3;
      3'h6: s = -5'sd2;
      3'h7: s = -5'sd1;
      default: s = 5'sd0;
    endcase
    return s;
  endfunction

  // steps registered as the trims are written
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      step_one_q <= '0;
      step_zero_q <= '0;
    end else if (ce_i && wr_en) begin
      if (wr_addr == gdc_pkg::SENSE_AMP_OFFSET_TRIM_OFS) begin
        step_one_q <= offset_step(wr_byte[gdc_pkg::AMP1_MSB:gdc_pkg::AMP1_LSB]);
        step_zero_q <= offset_step(wr_byte[gdc_pkg::AMP0_MSB:gdc_pkg::AMP0_LSB]);
      end
    end
  end

  assign amp_one_offset_step_o = step_one_q;
  assign amp_zero_offset_step_o = step_zero_q;

  gdc_boost_clkgen #(
    .CNT_W(10)
  ) u_clkgen (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .enable_i(boost_enable_bit_i),
    .div_sel_i(clk_ctrl_q[gdc_pkg::DIV_MSB:gdc_pkg::DIV_LSB]),
    .duty_sel_i(clk_ctrl_q[gdc_pkg::DUTY_MSB:gdc_pkg::DUTY_LSB]),
    .boost_clk_o(boost_clk_o)
  );
endmodule

// ==== sim/gdc_top_checker.sv ====
// Port-level checker for the gate-drive config block
`timescale 1ns/1ps
module gdc_top_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic config_write_lock_i,
  input wire logic boost_enable_bit_i,
  input wire logic pwm_reload_ok_i,
  input wire logic pwm_reload_i,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic boost_clk_o,
  input wire logic [7:0] boost_current_limit_o,
  input wire logic [1:0] phase_volt_select_o,
  input wire logic sel_bridge_supply_pin_o,
  input wire logic sel_phase_zero_pin_o,
  input wire logic sel_phase_one_pin_o,
  input wire logic [2:0] amp_one_offset_trim_o,
  input wire logic [2:0] amp_zero_offset_trim_o,
  input wire logic signed [4:0] amp_one_offset_step_o,
  input wire logic signed [4:0] amp_zero_offset_step_o
);
  logic [1:0] lock_cnt_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  function automatic logic signed [4:0] stp(input logic [2:0] c);
    if (c[1:0] == 2'h0) return 5'sh0;
    return c[2] ? ($signed({3'h0, c[1:0]}) - 5'sh4) : $signed({3'h0, c[1:0]});
  endfunction
  // Lock cycles seen, saturating past the sync lag
  always_ff @(posedge mclk_i) begin
    if (rst_i || !config_write_lock_i) lock_cnt_q <= 2'h0;
    else if (lock_cnt_q != 2'h3) lock_cnt_q <= lock_cnt_q + 2'h1;
  end
  AST_LOCK_LIMIT: assert property (config_write_lock_i && lock_cnt_q == 2'h3 |=> $stable(boost_current_limit_o))
    else $error("current limit changed while locked");
  AST_PH_HOLD: assert property (!(pwm_reload_ok_i && pwm_reload_i) |=> $stable(phase_volt_select_o))
    else $error("active phase select moved without reload");
  AST_PH_DECODE: assert property (sel_bridge_supply_pin_o == (phase_volt_select_o == 2'h0)
    && sel_phase_zero_pin_o == (phase_volt_select_o == 2'h1) && sel_phase_one_pin_o == (phase_volt_select_o == 2'h2))
    else $error("phase pin select decode wrong");
  AST_AMP1_STEP: assert property (amp_one_offset_step_o == stp(amp_one_offset_trim_o))
    else $error("amp one offset step wrong");
  AST_AMP0_STEP: assert property (amp_zero_offset_step_o == stp(amp_zero_offset_trim_o))
    else $error("amp zero offset step wrong");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_ANSWER: assert property (ce_i && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_BOOST_OFF: assert property (!boost_enable_bit_i && !$past(boost_enable_bit_i)
    && !$past(boost_enable_bit_i, 2) |-> !boost_clk_o) else $error("boost clock runs while disabled");
  AST_BOOST_MIN: assert property ($rose(boost_clk_o) |=> boost_clk_o)
    else $error("boost high phase below two cycles");
endmodule
bind gdc_top gdc_top_checker chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
  .config_write_lock_i(config_write_lock_i), .boost_enable_bit_i(boost_enable_bit_i),
  .pwm_reload_ok_i(pwm_reload_ok_i), .pwm_reload_i(pwm_reload_i), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .boost_clk_o(boost_clk_o), .boost_current_limit_o(boost_current_limit_o),
  .phase_volt_select_o(phase_volt_select_o), .sel_bridge_supply_pin_o(sel_bridge_supply_pin_o),
  .sel_phase_zero_pin_o(sel_phase_zero_pin_o), .sel_phase_one_pin_o(sel_phase_one_pin_o),
  .amp_one_offset_trim_o(amp_one_offset_trim_o), .amp_zero_offset_trim_o(amp_zero_offset_trim_o),
  .amp_one_offset_step_o(amp_one_offset_step_o), .amp_zero_offset_step_o(amp_zero_offset_step_o));

// ==== sim/test_gdc_top.sv ====
// Self-checking testbench for the gate-drive config block
`timescale 1ns/1ps
module test_gdc_top;
  logic mclk_i = 1'b0, rst_i = 1'b1, lock = 1'b0, ben = 1'b0, rok = 1'b0, rld = 1'b0, ce = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bclk, s_sup, s_z, s_o;
  logic [1:0] bresp, rresp, phsel, r;
  logic [7:0] climit;
  logic [2:0] tr1, tr0;
  logic signed [4:0] st1, st0;
  logic [31:0] seed = 32'h0001_0261;
  int err_total = 0, n_checks = 0;
  always #50 mclk_i = ~mclk_i;
  gdc_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .config_write_lock_i(lock), .boost_enable_bit_i(ben),
    .pwm_reload_ok_i(rok), .pwm_reload_i(rld), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .boost_clk_o(bclk),
    .boost_current_limit_o(climit), .phase_volt_select_o(phsel), .sel_bridge_supply_pin_o(s_sup),
    .sel_phase_zero_pin_o(s_z), .sel_phase_one_pin_o(s_o), .amp_one_offset_trim_o(tr1),
    .amp_zero_offset_trim_o(tr0), .amp_one_offset_step_o(st1), .amp_zero_offset_step_o(st0));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int ratio(input logic [4:0] c);
    int t[16] = '{16, 24, 32, 48, 64, 96, 100, 128, 192, 200, 256, 384, 400, 512, 768, 800};
    if (c[4]) return t[c[3:0]];
    return (c < 5'h06) ? 4 : 2 * int'(c[4:1]);
  endfunction
  function automatic logic signed [4:0] stp(input logic [2:0] c);
    if (c[1:0] == 2'h0) return 5'sh0;
    return c[2] ? ($signed({3'h0, c[1:0]}) - 5'sh4) : $signed({3'h0, c[1:0]});
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] resp);
    bit aw, w;
    @(posedge mclk_i);
    awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw = 0; w = 0;
    while (!(aw && w)) begin
      @(posedge mclk_i);
      if (!aw && awready) begin aw = 1; awvalid <= 1'b0; end
      if (!w && wready) begin w = 1; wvalid <= 1'b0; end
    end
    do @(posedge mclk_i); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge mclk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge mclk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge mclk_i);
    v = rdata; resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic reload(input logic ok, input logic ld);
    rok <= ok; rld <= ld;
    @(posedge mclk_i);
    rok <= 1'b0; rld <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic meas(output int hi, output int per);
    hi = 0; per = 0;
    repeat (2) begin
      while (bclk !== 1'b0) @(posedge mclk_i);
      while (bclk !== 1'b1) @(posedge mclk_i);
    end
    while (bclk === 1'b1) begin hi++; per++; @(posedge mclk_i); end
    while (bclk === 1'b0) begin per++; @(posedge mclk_i); end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge mclk_i);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    logic [31:0] v;
    logic [1:0] ph;
    logic [6:0] bc[8] = '{7'h03, 7'h15, 7'h1B, 7'h3E, 7'h43, 7'h59, 7'h7F, 7'h4C};
    int hi, per;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      rd(4'(a), d, r); chk(d, 32'h0, "reset value"); chk(32'(r), 32'(gdc_pkg::RESP_OKAY), "resp");
    end
    rd(4'h6, d, r); chk(32'(r), 32'(gdc_pkg::RESP_OKAY), "unaligned resp"); chk(d, 32'h0, "unaligned data");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      wr(4'h0, v[7:0], r); wr(4'h4, v[15:8], r); wr(4'hC, v[23:16], r);
      rd(4'h0, d, r); chk(d, {25'h0, v[6:0]}, "clock ctrl");
      rd(4'h4, d, r); chk(d, {24'h0, v[15:8]}, "limit reg"); chk(32'(climit), 32'(v[15:8]), "limit out");
      rd(4'hC, d, r); chk(d, {24'h0, v[23:16] & 8'h77}, "trim reg");
      chk(32'({tr1, tr0}), 32'({v[22:20], v[18:16]}), "trim outs");
    end
    wstrb <= 4'hE;
    wr(4'h4, ~v[15:8], r);
    wstrb <= 4'hF;
    rd(4'h4, d, r); chk(d, {24'h0, v[15:8]}, "strobe off");
    $display("test registers done");
    lock <= 1'b1;
    repeat (3) @(posedge mclk_i);
    wr(4'h0, ~v[7:0], r); chk(32'(r), 32'(gdc_pkg::RESP_OKAY), "locked resp");
    wr(4'h4, ~v[15:8], r); rd(4'h0, d, r); chk(d, {25'h0, v[6:0]}, "locked ctrl");
    rd(4'h4, d, r); chk(d, {24'h0, v[15:8]}, "locked limit"); chk(32'(climit), 32'(v[15:8]), "locked out");
    wr(4'hC, 8'h15, r); rd(4'hC, d, r); chk(d, 32'h15, "trim while locked");
    lock <= 1'b0;
    repeat (3) @(posedge mclk_i);
    $display("test lock done");
    ph = 2'h0;
    for (int c = 3; c >= 0; c--) begin
      wr(4'h8, 8'(c), r); rd(4'h8, d, r); chk(d, 32'(c), "buffered select");
      chk(32'(phsel), 32'(ph), "active before reload");
      reload(1'b0, 1'b1); chk(32'(phsel), 32'(ph), "reload without ok");
      reload(1'b1, 1'b0); chk(32'(phsel), 32'(ph), "ok without reload");
      reload(1'b1, 1'b1); ph = 2'(c); chk(32'(phsel), 32'(ph), "active after reload");
      chk(32'({s_sup, s_z, s_o}), 32'({ph == 2'h0, ph == 2'h1, ph == 2'h2}), "pin select");
    end
    wr(4'h8, 8'h02, r); ce <= 1'b0;
    reload(1'b1, 1'b1); chk(32'(phsel), 32'(ph), "reload while frozen");
    ce <= 1'b1;
    reload(1'b1, 1'b1); ph = 2'h2; chk(32'({s_sup, s_z, s_o, phsel}), 32'({3'b001, ph}), "reload after freeze");
    $display("test phase mux done");
    for (int c = 0; c < 8; c++) begin
      wr(4'hC, {1'b0, 3'(c), 1'b0, 3'(7 - c)}, r);
      chk(32'(st1), 32'(stp(3'(c))), "amp one step"); chk(32'(st0), 32'(stp(3'(7 - c))), "amp zero step");
    end
    $display("test offsets done");
    for (int i = 0; i < 11; i++) begin
      v = (i < 8) ? {25'h0, bc[i]} : rnd();
      ben <= 1'b0;
      wr(4'h0, {1'b0, v[6:0]}, r);
      ben <= 1'b1;
      meas(hi, per);
      chk(per, ratio(v[6:2]), "boost period");
      chk(hi, (v[6] && v[1:0] == 2'h3) ? (3 * ratio(v[6:2])) / 4 : ratio(v[6:2]) / 2, "boost high");
    end
    ben <= 1'b0;
    $display("test boost clock done");
    final_report();
  end
endmodule
